/* rtl/cfc_capture_ctrl.sv */
// chronological frame capture controller with AHB-Lite register slave
//
// Function
// R01 - wrapping modes keep writing until stopped
// R02 - data readable once first frame stored
// R03 - host drains fast enough, no overflow
// R04 - dma modes drain to host-supplied buffers
// R05 - selective fills buffer once, then halts
// R06 - selective stores only frames meeting trigger
// R07 - filtered wrapping modes filter while wrapping
// R08 - recording hides data from read port
// R09 - selective recording filters into recording sink
// R10 - trigger placement accepted from 0 to 100
// R11 - placement honoured only single and selective
// R12 - placement splits pre and post trigger
// R13 - disabled selection never pulses strobe
// R14 - stop selection pulses when one-shot fills
// R15 - stop selection pulses each half fill
// R16 - start selection pulses once on trigger
// R17 - selective start pulses per triggered frame
// R18 - report off, wait, trig, stopped, full, overload
// R19 - single mode halts and reports full
// R20 - unstorable frame halts with overload
// R21 - count frames captured since start
// R22 - distinct codes for modes and selections
// R23 - strobe one cycle, cycle after event
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
module cfc_capture_ctrl #(
	parameter int DEPTH = 1024
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire cfc_pkg::cfc_rx_t rx_word,
	output logic dma_valid,
	input wire logic dma_ready,
	output logic [31:0] dma_addr,
	output logic [cfc_pkg::DATA_W-1:0] dma_data,
	output logic rec_valid,
	input wire logic rec_ready,
	output logic [cfc_pkg::DATA_W-1:0] rec_data,
	output logic strobe_out
);
	localparam int CW = $clog2(DEPTH) + 1;
	localparam int HALF = DEPTH / 2;

	cfc_pkg::cfc_state_t state_ff;
	logic [2:0] mode_ff;
	logic [1:0] sel_ff;
	logic [6:0] pct_ff;
	logic [31:0] dma_base_ff;
	logic [31:0] dma_len_ff;
	logic [31:0] dma_off_ff;
	logic [31:0] dma_addr_ff;
	logic [31:0] frames_ff;
	logic avail_ff;
	logic in_frame_ff;
	logic keep_ff;
	logic [CW-1:0] half_cnt_ff;
	logic strobe_ff;
	logic [7:0] addr_ff;
	logic wr_ph_ff;
	logic [31:0] hrdata_ff;

	logic ap_ok;
	logic rd_ap;
	logic wen;
	logic start_cmd;
	logic stop_cmd;
	logic oneshot;
	logic filt;
	logic dma_mode;
	logic rec_mode;
	logic wrapping;
	logic [CW-1:0] pre_words;
	logic sof;
	logic keep;
	logic trig_now;
	logic storing;
	logic wr_try;
	logic wr;
	logic drop;
	logic pre_roll;
	logic host_pop;
	logic dma_fire;
	logic rec_fire;
	logic overload_ev;
	logic ev_full;
	logic ev_half;
	logic ev_trig;
	logic ev_frame;
	logic pulse_nxt;
	logic [31:0] rd_val;
	logic [cfc_pkg::DATA_W-1:0] pop_data;
	logic [CW-1:0] level;
	logic buf_full;
	logic buf_empty;

	// R22 mode classes
	function automatic logic is_oneshot(input logic [2:0] m);
		is_oneshot = (m == cfc_pkg::MODE_SINGLE) || (m == cfc_pkg::MODE_SELECTIVE);
	endfunction

	// R06 R07 filtered modes: selective, selective recording and the filtered wrapping modes
	function automatic logic is_filtered(input logic [2:0] m);
		is_filtered = (m == cfc_pkg::MODE_SELECTIVE) || (m == cfc_pkg::MODE_FILT_WRAP) ||
			(m == cfc_pkg::MODE_FILT_DMA_WRAP) || (m == cfc_pkg::MODE_RECORD_SEL);
	endfunction

	function automatic logic [2:0] state_code(input cfc_pkg::cfc_state_t s);
		case (s)
			cfc_pkg::CFC_WAIT: state_code = cfc_pkg::STAT_WAIT;
			cfc_pkg::CFC_TRIG: state_code = cfc_pkg::STAT_TRIG;
			cfc_pkg::CFC_STOPPED: state_code = cfc_pkg::STAT_STOPPED;
			cfc_pkg::CFC_FULL: state_code = cfc_pkg::STAT_FULL;
			cfc_pkg::CFC_OVLD: state_code = cfc_pkg::STAT_OVLD;
			default: state_code = cfc_pkg::STAT_OFF;
		endcase
	endfunction

	assign oneshot = is_oneshot(mode_ff);
	assign filt = is_filtered(mode_ff);
	assign dma_mode = (mode_ff == cfc_pkg::MODE_DMA_WRAP) ||
		(mode_ff == cfc_pkg::MODE_FILT_DMA_WRAP);
	assign rec_mode = (mode_ff == cfc_pkg::MODE_RECORD) || (mode_ff == cfc_pkg::MODE_RECORD_SEL);
	assign wrapping = !oneshot;

	// bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign ap_ok = hsel && hready && htrans[1];
	assign rd_ap = ap_ok && !hwrite;
	assign wen = wr_ph_ff;
	assign start_cmd = wen && (addr_ff == cfc_pkg::OFS_CTRL) && hwdata[cfc_pkg::CTRL_START_BIT];
	assign stop_cmd = wen && (addr_ff == cfc_pkg::OFS_CTRL) && hwdata[cfc_pkg::CTRL_STOP_BIT];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ph_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			wr_ph_ff <= ap_ok && hwrite;
			if (ap_ok) begin
				addr_ff <= {haddr[7:2], 2'b00};
			end
		end
	end

	// R11 placement only in single and selective
	// R12 pre-trigger share of the buffer
	assign pre_words = oneshot ? CW'((32'(pct_ff) * 32'(DEPTH)) / 32'd100) : '0;

	// frame acceptance decided on the first word, held for the rest
	assign sof = rx_word.valid && !in_frame_ff;
	// R06 only matching frames in filtered modes
	assign keep = in_frame_ff ? keep_ff : (!filt || rx_word.match);
	assign trig_now = (state_ff == cfc_pkg::CFC_WAIT) && sof && rx_word.trig;
	assign storing = (state_ff == cfc_pkg::CFC_TRIG) || trig_now ||
		((state_ff == cfc_pkg::CFC_WAIT) && oneshot && (pre_words != '0));
	assign wr_try = rx_word.valid && storing && keep;
	// R12 oldest pre-trigger words give way, even from a full ring
	assign pre_roll = (state_ff == cfc_pkg::CFC_WAIT) && !trig_now && oneshot &&
		(level >= pre_words);
	assign wr = wr_try && (!buf_full || pre_roll);
	assign drop = wr && pre_roll;
	// R20 wrapping modes cannot store a word
	assign overload_ev = wr_try && buf_full && wrapping;

	always_ff @(posedge clk) begin
		if (!reset_n || start_cmd) begin
			in_frame_ff <= 1'b0;
			keep_ff <= 1'b0;
		end else if (rx_word.valid) begin
			in_frame_ff <= !rx_word.last;
			keep_ff <= keep;
		end
	end

	// R08 recording hides data from the read port
	assign host_pop = rd_ap && (haddr[7:0] == cfc_pkg::OFS_RDDATA) && !rec_mode &&
		!dma_mode && !buf_empty && !drop;
	// R04 drained only into host-supplied buffers
	assign dma_valid = dma_mode && !buf_empty && (dma_len_ff != 32'h0);
	assign dma_fire = dma_valid && dma_ready;
	assign dma_data = pop_data;
	assign dma_addr = dma_addr_ff;
	// R09 recording modes feed the recording sink
	assign rec_valid = rec_mode && !buf_empty;
	assign rec_fire = rec_valid && rec_ready;
	assign rec_data = pop_data;

	// R01 ring storage
	cfc_ring_buf #(
		.W(cfc_pkg::DATA_W),
		.DEPTH(DEPTH)
	) cfc_ring_buf_i (
		.clk(clk),
		.reset_n(reset_n),
		.clr(start_cmd),
		.push(wr),
		.push_data(rx_word.data),
		.pop(drop || host_pop || dma_fire || rec_fire),
		.pop_data(pop_data),
		.level(level),
		.full(buf_full),
		.empty(buf_empty)
	);

	always_ff @(posedge clk) begin
		if (!reset_n || start_cmd) begin
			dma_off_ff <= 32'h0;
			dma_addr_ff <= start_cmd ? dma_base_ff : 32'h0;
		end else if (dma_fire) begin
			if (dma_off_ff >= dma_len_ff - 32'h1) begin
				dma_off_ff <= 32'h0;
				dma_addr_ff <= dma_base_ff;
			end else begin
				dma_off_ff <= dma_off_ff + 32'h1;
				dma_addr_ff <= dma_addr_ff + 32'h4;
			end
		end
	end

	// R18 monitor state
	always_ff @(posedge clk) begin
		if (!reset_n || stop_cmd) begin
			state_ff <= cfc_pkg::CFC_OFF;
		end else if (start_cmd) begin
			state_ff <= cfc_pkg::CFC_WAIT;
		end else begin
			case (state_ff)
				cfc_pkg::CFC_WAIT: begin
					if (overload_ev) begin
						state_ff <= cfc_pkg::CFC_OVLD;
					end else if (trig_now) begin
						state_ff <= cfc_pkg::CFC_TRIG;
					end
				end
				cfc_pkg::CFC_TRIG: begin
					// R20 halt until restarted
					if (overload_ev) begin
						state_ff <= cfc_pkg::CFC_OVLD;
					// R05 R19 one fill, then halt
					end else if (oneshot && buf_full) begin
						state_ff <= cfc_pkg::CFC_FULL;
					end else if (filt && sof && rx_word.stop) begin
						state_ff <= cfc_pkg::CFC_STOPPED;
					end
				end
				cfc_pkg::CFC_OFF, cfc_pkg::CFC_STOPPED, cfc_pkg::CFC_FULL,
				cfc_pkg::CFC_OVLD: begin
					state_ff <= state_ff;
				end
				default: begin
					state_ff <= cfc_pkg::CFC_OFF;
				end
			endcase
		end
	end

	// R21 frames since start
	// R02 data readable after the first stored frame
	always_ff @(posedge clk) begin
		if (!reset_n || start_cmd) begin
			frames_ff <= 32'h0;
			avail_ff <= 1'b0;
		end else if (wr && rx_word.last) begin
			frames_ff <= frames_ff + 32'h1;
			avail_ff <= 1'b1;
		end
	end

	// R15 count words toward each half of the buffer
	always_ff @(posedge clk) begin
		if (!reset_n || start_cmd) begin
			half_cnt_ff <= '0;
		end else if (wr && wrapping) begin
			half_cnt_ff <= ev_half ? '0 : half_cnt_ff + 1'b1;
		end
	end

	assign ev_full = (state_ff == cfc_pkg::CFC_TRIG) && oneshot && buf_full && !overload_ev &&
		!start_cmd && !stop_cmd;
	assign ev_half = wr && wrapping && (half_cnt_ff == CW'(HALF - 1));
	assign ev_trig = trig_now && !filt && !start_cmd && !stop_cmd;
	assign ev_frame = filt && wr && sof && !start_cmd && !stop_cmd;

	// R13 R14 R15 R16 R17 strobe sources
	always_comb begin
		case (sel_ff)
			cfc_pkg::PULSE_STOP: pulse_nxt = ev_full || ev_half;
			cfc_pkg::PULSE_START: pulse_nxt = ev_trig || ev_frame;
			default: pulse_nxt = 1'b0;
		endcase
	end

	// R23 registered one-cycle pulse
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= pulse_nxt;
		end
	end
	assign strobe_out = strobe_ff;

	// mode and strobe selection take effect only while the monitor is off
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_ff <= cfc_pkg::MODE_RESET;
			sel_ff <= cfc_pkg::PULSE_RESET;
		end else if (wen && (addr_ff == cfc_pkg::OFS_CTRL) && (state_ff == cfc_pkg::CFC_OFF) &&
			!hwdata[cfc_pkg::CTRL_START_BIT]) begin
			mode_ff <= hwdata[cfc_pkg::CTRL_MODE_LSB +: 3];
			sel_ff <= hwdata[cfc_pkg::CTRL_SEL_LSB +: 2];
		end
	end

	// R10 placement clamped to 100
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pct_ff <= cfc_pkg::PCT_RESET;
		end else if (wen && (addr_ff == cfc_pkg::OFS_TRIGPOS)) begin
			pct_ff <= (hwdata > 32'(cfc_pkg::PCT_MAX)) ? cfc_pkg::PCT_MAX : hwdata[6:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dma_base_ff <= 32'h0;
			dma_len_ff <= 32'h0;
		end else if (wen && (addr_ff == cfc_pkg::OFS_DMA_BASE)) begin
			dma_base_ff <= {hwdata[31:2], 2'b00};
		end else if (wen && (addr_ff == cfc_pkg::OFS_DMA_LEN)) begin
			dma_len_ff <= hwdata;
		end
	end

	always_comb begin
		rd_val = 32'h0;
		case ({haddr[7:2], 2'b00})
			cfc_pkg::OFS_CTRL: rd_val = {26'h0, sel_ff, 1'b0, mode_ff};
			cfc_pkg::OFS_TRIGPOS: rd_val = {25'h0, pct_ff};
			cfc_pkg::OFS_STATUS: begin
				rd_val[2:0] = state_code(state_ff);
				rd_val[cfc_pkg::STAT_AVAIL_BIT] = avail_ff && !rec_mode;
				rd_val[cfc_pkg::STAT_EMPTY_BIT] = buf_empty;
			end
			cfc_pkg::OFS_FRAMES: rd_val = frames_ff;
			cfc_pkg::OFS_RDDATA: rd_val = host_pop ? pop_data : 32'h0;
			cfc_pkg::OFS_FILL: rd_val = 32'(level);
			cfc_pkg::OFS_DMA_BASE: rd_val = dma_base_ff;
			cfc_pkg::OFS_DMA_LEN: rd_val = dma_len_ff;
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hrdata_ff <= 32'h0;
		end else begin
			hrdata_ff <= rd_ap ? rd_val : 32'h0;
		end
	end

	a_strobe_disabled: assert property (@(posedge clk) disable iff (!reset_n) // R13
		(sel_ff == cfc_pkg::PULSE_DIS) && ($past(sel_ff) == cfc_pkg::PULSE_DIS) |-> !strobe_out)
		else $error("strobe pulsed while disabled");
	a_strobe_on_full: assert property (@(posedge clk) disable iff (!reset_n) // R14
		$rose(state_ff == cfc_pkg::CFC_FULL) && ($past(sel_ff) == cfc_pkg::PULSE_STOP)
		|-> strobe_out)
		else $error("no strobe when buffer filled");
	a_strobe_on_trig: assert property (@(posedge clk) disable iff (!reset_n) // R16
		(sel_ff == cfc_pkg::PULSE_START) && !filt && trig_now && !stop_cmd && !start_cmd
		|=> strobe_out ##1 !strobe_out)
		else $error("trigger strobe missing or long");
	a_full_halts: assert property (@(posedge clk) disable iff (!reset_n) // R19
		(state_ff == cfc_pkg::CFC_FULL) |-> !wr)
		else $error("write while full");
	a_ovld_sticky: assert property (@(posedge clk) disable iff (!reset_n) // R20
		(state_ff == cfc_pkg::CFC_OVLD) && !start_cmd && !stop_cmd
		|=> (state_ff == cfc_pkg::CFC_OVLD))
		else $error("overload left without restart");
	a_filter_match: assert property (@(posedge clk) disable iff (!reset_n) // R06
		wr && sof && filt |-> rx_word.match)
		else $error("unmatched frame stored");
	a_rec_hidden: assert property (@(posedge clk) disable iff (!reset_n) // R08
		rec_mode |-> !host_pop)
		else $error("read port popped in recording");
	a_pct_range: assert property (@(posedge clk) disable iff (!reset_n) // R10
		pct_ff <= cfc_pkg::PCT_MAX)
		else $error("placement above 100");
	a_frame_count: assert property (@(posedge clk) disable iff (!reset_n) // R21
		wr && rx_word.last && !start_cmd |=> frames_ff == $past(frames_ff) + 32'h1)
		else $error("frame count not advanced");
	a_pre_limit: assert property (@(posedge clk) disable iff (!reset_n) // R12
		(state_ff == cfc_pkg::CFC_WAIT) && oneshot && !start_cmd |-> level <= pre_words)
		else $error("pre-trigger share exceeded");

	c_full: cover property (@(posedge clk) $rose(state_ff == cfc_pkg::CFC_FULL));
	c_ovld: cover property (@(posedge clk) $rose(state_ff == cfc_pkg::CFC_OVLD));
	c_half: cover property (@(posedge clk) ev_half && (sel_ff == cfc_pkg::PULSE_STOP));
	c_stopped: cover property (@(posedge clk) $rose(state_ff == cfc_pkg::CFC_STOPPED));

endmodule // cfc_capture_ctrl

/* rtl/cfc_pkg.sv */
// shared constants, codes and carrier types of the frame capture controller
package cfc_pkg;

	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TRIGPOS = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FRAMES = 8'h0C;
	localparam logic [7:0] OFS_RDDATA = 8'h10;
	localparam logic [7:0] OFS_FILL = 8'h14;
	localparam logic [7:0] OFS_DMA_BASE = 8'h18;
	localparam logic [7:0] OFS_DMA_LEN = 8'h1C;

	// control and status register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SEL_LSB = 4;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_STOP_BIT = 9;
	localparam int STAT_AVAIL_BIT = 8;
	localparam int STAT_EMPTY_BIT = 9;

	// capture_kind_select codes
	localparam logic [2:0] MODE_SINGLE = 3'h0;
	localparam logic [2:0] MODE_CONT = 3'h1;
	localparam logic [2:0] MODE_DMA_WRAP = 3'h2;
	localparam logic [2:0] MODE_SELECTIVE = 3'h3;
	localparam logic [2:0] MODE_FILT_WRAP = 3'h4;
	localparam logic [2:0] MODE_FILT_DMA_WRAP = 3'h5;
	localparam logic [2:0] MODE_RECORD = 3'h6;
	localparam logic [2:0] MODE_RECORD_SEL = 3'h7;

	// discrete_pulse_select codes
	localparam logic [1:0] PULSE_DIS = 2'h0;
	localparam logic [1:0] PULSE_STOP = 2'h1;
	localparam logic [1:0] PULSE_START = 2'h2;

	// monitor state codes as software sees them
	localparam logic [2:0] STAT_OFF = 3'h0;
	localparam logic [2:0] STAT_WAIT = 3'h1;
	localparam logic [2:0] STAT_TRIG = 3'h2;
	localparam logic [2:0] STAT_STOPPED = 3'h3;
	localparam logic [2:0] STAT_FULL = 3'h4;
	localparam logic [2:0] STAT_OVLD = 3'h5;

	localparam logic [6:0] PCT_MAX = 7'h64;
	localparam logic [6:0] PCT_RESET = 7'h00;
	localparam logic [2:0] MODE_RESET = MODE_SINGLE;
	localparam logic [1:0] PULSE_RESET = PULSE_DIS;

	typedef enum logic [5:0] {
		CFC_OFF = 6'h01,
		CFC_WAIT = 6'h02,
		CFC_TRIG = 6'h04,
		CFC_STOPPED = 6'h08,
		CFC_FULL = 6'h10,
		CFC_OVLD = 6'h20
	} cfc_state_t;

	// one word of a received frame as delivered by the receive path
	typedef struct packed {
		logic valid;
		logic last;
		logic match;
		logic trig;
		logic stop;
		logic [DATA_W-1:0] data;
	} cfc_rx_t;

endpackage

/* rtl/cfc_ring_buf.sv */
// circular monitor buffer with push, pop and fill level
module cfc_ring_buf #(
	parameter int W = 32,
	parameter int DEPTH = 1024
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clr,
	input wire logic push,
	input wire logic [W-1:0] push_data,
	input wire logic pop,
	output logic [W-1:0] pop_data,
	output logic [$clog2(DEPTH):0] level,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] level_ff;
	logic do_push;
	logic do_pop;

	// a full ring takes a word only while another leaves in the same cycle
	assign do_push = push && (!full || pop);
	assign do_pop = pop && !empty;
	assign full = (level_ff == (AW+1)'(DEPTH));
	assign empty = (level_ff == '0);
	assign level = level_ff;
	assign pop_data = mem[rd_ptr_ff];

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= push_data;
		end
	end

	// pointers wrap so writing continues around the ring
	always_ff @(posedge clk) begin
		if (!reset_n || clr) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			level_ff <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (do_pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			if (do_push && !do_pop) begin
				level_ff <= level_ff + 1'b1;
			end else if (do_pop && !do_push) begin
				level_ff <= level_ff - 1'b1;
			end
		end
	end

endmodule // cfc_ring_buf

/* test/cfc_sink_model.sv */
// dma and recording sink standing in for host memory and the recorder
module cfc_sink_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic dma_valid,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_data,
	input wire logic rec_valid,
	input wire logic [31:0] rec_data,
	output logic dma_ready,
	output logic rec_ready,
	output int n_dma,
	output int n_rec,
	output logic [31:0] last_addr,
	output logic [31:0] last_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic tick_ff;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tick_ff <= 1'b0;
			n_dma <= 0;
			n_rec <= 0;
			last_addr <= 32'h0;
			last_data <= 32'h0;
		end else begin
			tick_ff <= ~tick_ff;
			// words land in the host buffer
			if (dma_valid && dma_ready) begin
				n_dma <= n_dma + 1;
				last_addr <= dma_addr;
				last_data <= dma_data;
			end
			if (rec_valid && rec_ready) begin
				n_rec <= n_rec + 1;
				last_data <= rec_data;
			end
		end
	end
	// drains every cycle, or every other one when slow
	assign dma_ready = !slow || tick_ff;
	assign rec_ready = !slow || tick_ff;
endmodule // cfc_sink_model

/* test/test_cfc_capture_ctrl.sv */
// self-checking bench for the frame capture controller
module test_cfc_capture_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = 16;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, dma_valid, dma_ready, rec_valid, rec_ready, strobe_out;
	logic [31:0] hrdata, dma_addr, dma_data, rec_data, last_addr, last_data, v;
	logic slow = 1'b0;
	cfc_pkg::cfc_rx_t rx = '0;
	int n_dma, n_rec, s0;
	int n_strobe = 0;
	int cyc = 0;
	int err_count = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	cfc_capture_ctrl #(.DEPTH(DEPTH)) cfc_capture_ctrl_i (.clk(clk), .reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.rx_word(rx), .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_addr(dma_addr),
		.dma_data(dma_data), .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data),
		.strobe_out(strobe_out));
	cfc_sink_model cfc_sink_model_i (.clk(clk), .reset_n(reset_n), .slow(slow),
		.dma_valid(dma_valid), .dma_addr(dma_addr), .dma_data(dma_data), .rec_valid(rec_valid),
		.rec_data(rec_data), .dma_ready(dma_ready), .rec_ready(rec_ready), .n_dma(n_dma),
		.n_rec(n_rec), .last_addr(last_addr), .last_data(last_data));
	always @(posedge clk) begin
		cyc++;
		if (strobe_out === 1'b1) n_strobe++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// single transfer; the wait covers any number of wait states
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, v);
	endtask
	task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, v);
		chk(name, exp, v);
	endtask
	task automatic restart(input logic [31:0] ctrl);
		// empty the ring before the new mode, so no stale words drain to a sink
		wr(cfc_pkg::OFS_CTRL, 32'h200);
		wr(cfc_pkg::OFS_CTRL, 32'h100);
		wr(cfc_pkg::OFS_CTRL, 32'h200);
		wr(cfc_pkg::OFS_CTRL, ctrl);
		wr(cfc_pkg::OFS_CTRL, 32'h100);
		s0 = n_strobe;
	endtask
	// one-word frames, data counting up from d0
	task automatic send(input int n, input logic tr, input logic m, input logic [31:0] d0);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx <= '{1'b1, 1'b1, m, tr, 1'b0, d0 + 32'(i)};
		end
		@(posedge clk);
		rx <= '0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rc("ctrl", cfc_pkg::OFS_CTRL, 32'h0);
		rc("trigpos", cfc_pkg::OFS_TRIGPOS, {25'h0, cfc_pkg::PCT_RESET});
		rc("status", cfc_pkg::OFS_STATUS, 32'h200);
		rc("frames", cfc_pkg::OFS_FRAMES, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		rc("unmapped", 8'h20, 32'h0);
		wr(cfc_pkg::OFS_TRIGPOS, 32'hC8);
		rc("pct clamp", cfc_pkg::OFS_TRIGPOS, {25'h0, cfc_pkg::PCT_MAX});
		wr(cfc_pkg::OFS_TRIGPOS, 32'h32);
		done("reset");
		restart(32'h20);
		rc("wait", cfc_pkg::OFS_STATUS, 32'h201);
		send(12, 1'b0, 1'b1, 32'hA0);
		idle(2);
		rc("pre fill", cfc_pkg::OFS_FILL, 32'(50 * DEPTH / 100));
		@(posedge clk);
		rx <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 32'hB0};
		@(posedge clk);
		rx <= '0;
		@(posedge clk);
		chk("start pulse", 32'h1, {31'h0, strobe_out});
		@(posedge clk);
		chk("pulse width", 32'h0, {31'h0, strobe_out});
		send(DEPTH / 2 - 1, 1'b1, 1'b1, 32'hC0);
		idle(3);
		rc("full", cfc_pkg::OFS_STATUS, 32'h104);
		chk("one pulse", 32'h1, 32'(n_strobe - s0));
		rc("oldest", cfc_pkg::OFS_RDDATA, 32'(32'hAC - 50 * DEPTH / 100));
		done("single");
		restart(32'h11);
		send(1, 1'b1, 1'b1, 32'hD0);
		idle(2);
		rc("first avail", cfc_pkg::OFS_STATUS, 32'h102);
		send(DEPTH / 2 - 1, 1'b0, 1'b1, 32'hD1);
		idle(3);
		chk("half pulse", 32'h1, 32'(n_strobe - s0));
		for (int i = 0; i < 4; i++) rc("order", cfc_pkg::OFS_RDDATA, 32'hD0 + 32'(i));
		send(DEPTH / 2, 1'b0, 1'b1, 32'hD8);
		idle(3);
		chk("second half", 32'h2, 32'(n_strobe - s0));
		rc("frames", cfc_pkg::OFS_FRAMES, 32'(DEPTH));
		rc("fill", cfc_pkg::OFS_FILL, 32'(DEPTH - 4));
		send(5, 1'b0, 1'b1, 32'hE0);
		idle(2);
		bus(1'b0, cfc_pkg::OFS_STATUS, 32'h0, v);
		chk("overload", {29'h0, cfc_pkg::STAT_OVLD}, v & 32'h7);
		done("continuous");
		slow <= 1'b1;
		restart(32'h06);
		send(1, 1'b1, 1'b1, 32'h50);
		send(9, 1'b0, 1'b1, 32'h51);
		idle(30);
		chk("rec count", 32'hA, 32'(n_rec));
		chk("rec last", 32'h59, last_data);
		rc("no readout", cfc_pkg::OFS_RDDATA, 32'h0);
		bus(1'b0, cfc_pkg::OFS_STATUS, 32'h0, v);
		chk("no avail", 32'h0, v & 32'h100);
		chk("no pulse", 32'h0, 32'(n_strobe - s0));
		done("recording");
		wr(cfc_pkg::OFS_CTRL, 32'h200);
		wr(cfc_pkg::OFS_DMA_BASE, 32'h100);
		wr(cfc_pkg::OFS_DMA_LEN, 32'h4);
		restart(32'h02);
		send(1, 1'b1, 1'b1, 32'h60);
		send(5, 1'b0, 1'b1, 32'h61);
		idle(30);
		chk("dma count", 32'h6, 32'(n_dma));
		chk("dma wrap", 32'(32'h100 + 4 * ((6 - 1) % 4)), last_addr);
		chk("dma last", 32'h65, last_data);
		done("dma");
		slow <= 1'b0;
		wr(cfc_pkg::OFS_CTRL, 32'h200);
		wr(cfc_pkg::OFS_TRIGPOS, 32'h0);
		restart(32'h23);
		send(1, 1'b1, 1'b1, 32'h10);
		send(3, 1'b0, 1'b0, 32'h20);
		send(3, 1'b0, 1'b1, 32'h30);
		idle(2);
		rc("filtered fill", cfc_pkg::OFS_FILL, 32'h4);
		chk("frame pulses", 32'h4, 32'(n_strobe - s0));
		rc("filtered head", cfc_pkg::OFS_RDDATA, 32'h10);
		rc("filtered next", cfc_pkg::OFS_RDDATA, 32'h30);
		send(DEPTH, 1'b0, 1'b1, 32'h40);
		idle(3);
		rc("one fill", cfc_pkg::OFS_FILL, 32'(DEPTH));
		bus(1'b0, cfc_pkg::OFS_STATUS, 32'h0, v);
		chk("halted", {29'h0, cfc_pkg::STAT_FULL}, v & 32'h7);
		done("selective");
		restart(32'h10);
		send(1, 1'b1, 1'b1, 32'h70);
		send(DEPTH - 1, 1'b0, 1'b1, 32'h71);
		idle(3);
		chk("stop pulse", 32'h1, 32'(n_strobe - s0));
		done("stop strobe");
		restart(32'h04);
		send(1, 1'b1, 1'b1, 32'h80);
		send(2, 1'b0, 1'b0, 32'h81);
		@(posedge clk);
		rx <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 32'h90};
		@(posedge clk);
		rx <= '0;
		send(1, 1'b0, 1'b1, 32'hA0);
		idle(2);
		rc("filtered wrap", cfc_pkg::OFS_FILL, 32'h2);
		bus(1'b0, cfc_pkg::OFS_STATUS, 32'h0, v);
		chk("stopped", {29'h0, cfc_pkg::STAT_STOPPED}, v & 32'h7);
		done("filtered stop");
		give_verdict();
	end
endmodule // test_cfc_capture_ctrl
